/* File: rtl/capstan_time_base_comparator.sv */
// Capstan speed time base comparator: squarer, two one-shots, early reset
`timescale 1ns/1ps
module capstan_time_base_comparator (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tachLevel,
  input wire logic [capstan_tbc_pkg::TRIM_WIDTH-1:0] period_trim_setting,
  output logic squaredTach,
  output logic compOut,
  output logic stage1Busy,
  output logic stage2Busy
);
  import capstan_tbc_pkg::*;

  // ----------------------------------------
  // Squaring stage
  // ----------------------------------------
  logic sqWave;
  logic trigPulse;

  tach_squarer squarer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tachLevel(tachLevel),
    .squareOut(sqWave),
    .fallPulse(trigPulse)
  );

  // ----------------------------------------
  // Trim capture
  // ----------------------------------------
  // Trim is a static setting from another domain, so pass it through two flops
  logic [TRIM_WIDTH-1:0] trimA_r;
  logic [TRIM_WIDTH-1:0] trimB_r;
  logic [TRIM_WIDTH-1:0] trimUse;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trimA_r <= TRIM_DEFAULT;
      trimB_r <= TRIM_DEFAULT;
    end else begin
      trimA_r <= period_trim_setting;
      trimB_r <= trimA_r;
    end
  end

  // Zero trim would wrap the stage two count to its maximum, so fall back to nominal
  assign trimUse = (trimB_r == CNT2_RESET) ? TRIM_DEFAULT : trimB_r;

  // ----------------------------------------
  // First one-shot
  // ----------------------------------------
  shot_state_type s1State_r;
  shot_state_type s1State_nxt;
  logic [CNT1_WIDTH-1:0] cnt1_r;
  logic [CNT1_WIDTH-1:0] cnt1_nxt;
  logic s1Start;
  logic s1End;

  always_comb begin
    s1State_nxt = s1State_r;
    cnt1_nxt = cnt1_r;
    s1Start = 1'b0;
    s1End = 1'b0;
    unique case (s1State_r)
      SHOT_IDLE: begin
        if (trigPulse) begin
          s1State_nxt = SHOT_ACTIVE;
          cnt1_nxt = STAGE1_COUNT - 16'h0001;
          s1Start = 1'b1;
        end
      end
      SHOT_ACTIVE: begin
        if (cnt1_r == CNT1_RESET) begin
          s1State_nxt = SHOT_IDLE;
          s1End = 1'b1;
        end else begin
          cnt1_nxt = cnt1_r - 16'h0001;
        end
      end
      default: begin
        s1State_nxt = SHOT_IDLE;
        cnt1_nxt = CNT1_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1State_r <= SHOT_IDLE;
      cnt1_r <= CNT1_RESET;
    end else begin
      s1State_r <= s1State_nxt;
      cnt1_r <= cnt1_nxt;
    end
  end

  // ----------------------------------------
  // Second one-shot
  // ----------------------------------------
  shot_state_type s2State_r;
  shot_state_type s2State_nxt;
  logic [TRIM_WIDTH-1:0] cnt2_r;
  logic [TRIM_WIDTH-1:0] cnt2_nxt;
  logic [TRIM_WIDTH-1:0] elapsed_r;
  logic [TRIM_WIDTH-1:0] elapsed_nxt;
  logic earlyOk;

  assign earlyOk = elapsed_r >= (trimUse >> 1);

  always_comb begin
    s2State_nxt = s2State_r;
    cnt2_nxt = cnt2_r;
    elapsed_nxt = elapsed_r;
    unique case (s2State_r)
      SHOT_IDLE: begin
        if (s1End) begin
          s2State_nxt = SHOT_ACTIVE;
          cnt2_nxt = trimUse - 20'h0_0001;
          elapsed_nxt = 20'h0_0001;
        end
      end
      SHOT_ACTIVE: begin
        if (s1Start && earlyOk) begin
          s2State_nxt = SHOT_IDLE;
          cnt2_nxt = CNT2_RESET;
          elapsed_nxt = CNT2_RESET;
        end else if (cnt2_r == CNT2_RESET) begin
          s2State_nxt = SHOT_IDLE;
          elapsed_nxt = CNT2_RESET;
        end else begin
          cnt2_nxt = cnt2_r - 20'h0_0001;
          elapsed_nxt = elapsed_r + 20'h0_0001;
        end
      end
      default: begin
        s2State_nxt = SHOT_IDLE;
        cnt2_nxt = CNT2_RESET;
        elapsed_nxt = CNT2_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s2State_r <= SHOT_IDLE;
      cnt2_r <= CNT2_RESET;
      elapsed_r <= CNT2_RESET;
    end else begin
      s2State_r <= s2State_nxt;
      cnt2_r <= cnt2_nxt;
      elapsed_r <= elapsed_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic square_r;
  logic comp_r;
  logic comp_nxt;
  logic busy1_r;
  logic busy2_r;

  // inverted stage two
  // Stage two is active-low, so its inverse is high while active
  assign comp_nxt = (s2State_nxt == SHOT_ACTIVE) ? ~COMP_OUT_IDLE : COMP_OUT_IDLE;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      square_r <= 1'b0;
      comp_r <= COMP_OUT_IDLE;
      busy1_r <= 1'b0;
      busy2_r <= 1'b0;
    end else begin
      square_r <= sqWave;
      comp_r <= comp_nxt;
      busy1_r <= (s1State_nxt == SHOT_ACTIVE);
      busy2_r <= (s2State_nxt == SHOT_ACTIVE);
    end
  end

  assign squaredTach = square_r;
  assign compOut = comp_r;
  assign stage1Busy = busy1_r;
  assign stage2Busy = busy2_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s1Fire;
    s1State_r == SHOT_IDLE && trigPulse;
  endsequence

  stage1_width_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s1Fire |=> (s1State_r == SHOT_ACTIVE) && cnt1_r == STAGE1_COUNT - 16'h0001)
    else $error("stage one did not start with full count");
  stage1_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s1State_r == SHOT_ACTIVE && cnt1_r == CNT1_RESET) |=> s1State_r == SHOT_IDLE)
    else $error("stage one did not end at zero count");
  chain_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s1End && s2State_r == SHOT_IDLE) |=> s2State_r == SHOT_ACTIVE)
    else $error("stage two not started by stage one end");
  stage2_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s2State_r == SHOT_ACTIVE && cnt2_r == CNT2_RESET && !s1Start)
      |=> s2State_r == SHOT_IDLE)
    else $error("stage two overran its count");
  early_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s2State_r == SHOT_ACTIVE && s1Start && !earlyOk && cnt2_r != CNT2_RESET)
      |=> s2State_r == SHOT_ACTIVE)
    else $error("early reset honoured too soon");
  early_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s2State_r == SHOT_ACTIVE && s1Start && earlyOk) |=> s2State_r == SHOT_IDLE)
    else $error("early reset ignored");
  output_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    compOut == (s2State_r == SHOT_ACTIVE))
    else $error("output not inverse of stage two");
  active_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stage2Busy |-> elapsed_r <= trimUse)
    else $error("active interval too long");
  reset_idle_a: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> !compOut && !stage2Busy)
    else $error("not idle after reset");
  timing_trim_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s1End && s2State_r == SHOT_IDLE) |=> cnt2_r == $past(trimUse) - 20'h0_0001)
    else $error("stage two ignores trim");

endmodule : capstan_time_base_comparator

/* File: rtl/capstan_tbc_pkg.sv */
// Constants and types shared by the capstan time base comparator
package capstan_tbc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAGE1_TIME_US = 220;
  localparam int STAGE2_TIME_US = 3000;
  localparam int STAGE1_CYCLES = (STAGE1_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int STAGE2_CYCLES = (STAGE2_TIME_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Counter widths and reset values
  // ----------------------------------------
  localparam int TRIM_WIDTH = 20;
  localparam int CNT1_WIDTH = 16;
  localparam logic [CNT1_WIDTH-1:0] CNT1_RESET = 16'h0000;
  localparam logic [TRIM_WIDTH-1:0] CNT2_RESET = 20'h0_0000;
  localparam logic [CNT1_WIDTH-1:0] STAGE1_COUNT = CNT1_WIDTH'(STAGE1_CYCLES);
  localparam logic [TRIM_WIDTH-1:0] TRIM_DEFAULT = TRIM_WIDTH'(STAGE2_CYCLES);
  localparam logic COMP_OUT_IDLE = 1'b0;

  // ----------------------------------------
  // One-shot states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SHOT_IDLE = 2'b01,
    SHOT_ACTIVE = 2'b10
  } shot_state_type;

endpackage : capstan_tbc_pkg

/* File: rtl/tach_squarer.sv */
// Tachometer synchroniser and squaring stage
`timescale 1ns/1ps
module tach_squarer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tachLevel,
  output logic squareOut,
  output logic fallPulse
);
  import capstan_tbc_pkg::*;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  logic syncA_r;
  logic syncB_r;
  logic square_r;
  logic square_nxt;
  logic fall_r;
  logic fall_nxt;

  always_comb begin
    square_nxt = syncB_r;
    fall_nxt = square_r & ~syncB_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      square_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      syncA_r <= tachLevel;
      syncB_r <= syncA_r;
      square_r <= square_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign squareOut = square_r;
  assign fallPulse = fall_r;

  single_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fallPulse |=> !fallPulse) else $error("fall pulse longer than one cycle");
  fall_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fallPulse |-> $past(square_r, 1) && !square_r)
    else $error("fall pulse without falling edge");

endmodule : tach_squarer

/* File: sim/tach_sensor_model.sv */
// Behavioural optical tachometer driving the squarer input
`timescale 1ns/1ps
module tach_sensor_model (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [31:0] halfCycles,
  output logic tachLevel,
  output int fallCount
);
  int phase;
  logic go;

  // shortened period
  // Flywheel at rest shows light, so idle is high
  initial begin
    tachLevel = 1'b1;
    fallCount = 0;
    phase = 0;
    go = 1'b0;
    forever begin
      @(posedge ref_clk);
      // Run taken at the edge, so the bench's update just after it cannot race
      go = run;
      #1;
      if (!go) begin
        tachLevel = 1'b1;
        // Resting just before a slot edge keeps each run short
        phase = int'(halfCycles) - 4;
      end else if (phase + 1 >= halfCycles) begin
        phase = 0;
        tachLevel = ~tachLevel;
        if (!tachLevel) begin
          fallCount++;
        end
      end else begin
        phase++;
      end
    end
  end
endmodule : tach_sensor_model

/* File: sim/capstan_time_base_comparator_tb.sv */
// Self-checking bench for the capstan time base comparator
`timescale 1ns/1ps
module capstan_time_base_comparator_tb;
  import capstan_tbc_pkg::*;

  typedef struct {
    logic [TRIM_WIDTH-1:0] trim;
    logic [31:0] half;
    int lo;
    int hi;
  } row_type;

  localparam int LIM = 40000;
  // Normal, early reset honoured, early reset refused
  row_type rows [3] = '{
    '{20'h0_03E8, 12000, 999, 1000},
    '{20'h0_07D0, 11700, 23400 - STAGE1_CYCLES - 2, 23400 - STAGE1_CYCLES + 2},
    '{20'h0_07D0, 11300, 1999, 2000}
  };

  logic ref_clk;
  logic rst_n;
  logic [TRIM_WIDTH-1:0] trim;
  logic run;
  logic [31:0] half;
  logic tachLevel;
  logic squaredTach, compOut, stage1Busy, stage2Busy;
  int fallCount;
  int err_total;
  int total_checks;
  int s1Rises;
  logic s1Prev;
  int w1, w2, w3, w4, t;

  tach_sensor_model sensor (.ref_clk(ref_clk), .run(run), .halfCycles(half),
    .tachLevel(tachLevel), .fallCount(fallCount));

  capstan_time_base_comparator uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .tachLevel(tachLevel), .period_trim_setting(trim), .squaredTach(squaredTach),
    .compOut(compOut), .stage1Busy(stage1Busy), .stage2Busy(stage2Busy));

  initial begin
    ref_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Checking tasks
  // ----------------------------------------
  task automatic check(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("unexpected at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : check

  task automatic checkBits(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: outputs %b not %b", $time, got, exp);
    end
  endtask : checkBits

  function automatic logic pick(input int k);
    case (k)
      0: return squaredTach;
      1: return compOut;
      2: return stage1Busy;
      default: return stage2Busy;
    endcase
  endfunction : pick

  // Length of the next segment at level pol, sampled on falling clock edges
  task automatic width(input int k, input logic pol, output int n);
    int w;
    w = 0;
    n = 0;
    while (pick(k) !== pol && w < LIM) begin
      @(negedge ref_clk);
      w++;
    end
    while (pick(k) === pol && n < LIM) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : width

  task automatic resetDut(input logic [TRIM_WIDTH-1:0] tv, input logic [31:0] hv);
    @(posedge ref_clk);
    #1;
    run = 1'b0;
    rst_n = 1'b0;
    trim = tv;
    half = hv;
    repeat (20) @(posedge ref_clk);
    #1;
    checkBits({squaredTach, compOut, stage1Busy, stage2Busy}, 4'h0);
    rst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    // Sensor rests in light, so the squared wave idles high
    checkBits({squaredTach, compOut, stage1Busy, stage2Busy}, 4'h8);
  endtask : resetDut

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // Stage one rises, one per accepted trigger
  always @(negedge ref_clk) begin
    if (stage1Busy === 1'b1 && !s1Prev) begin
      s1Rises++;
    end
    s1Prev = (stage1Busy === 1'b1);
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    total_checks = 0;
    s1Rises = 0;
    s1Prev = 1'b0;
    run = 1'b0;
    half = 32'h0000_2EE0;
    trim = 20'h0_03E8;
    rst_n = 1'b0;
    foreach (rows[i]) begin
      resetDut(rows[i].trim, rows[i].half);
      run = 1'b1;
      fork
        width(0, 1'b0, w1);
        width(2, 1'b1, w2);
        width(1, 1'b1, w3);
        width(3, 1'b1, w4);
      join
      check(w1, rows[i].half - 1, rows[i].half + 1);
      check(w2, STAGE1_CYCLES, STAGE1_CYCLES + 1);
      check(w3, rows[i].lo, rows[i].hi);
      check(w4, rows[i].lo, rows[i].hi);
      @(posedge ref_clk);
      #1;
      run = 1'b0;
      repeat (30) @(posedge ref_clk);
      check(s1Rises, fallCount, fallCount);
    end
    // Reset landing in the middle of a stage-one pulse
    resetDut(20'h0_03E8, 32'h0000_0064);
    run = 1'b1;
    t = 0;
    while (stage1Busy !== 1'b1 && t < 300) begin
      @(negedge ref_clk);
      t++;
    end
    @(posedge ref_clk);
    #1;
    rst_n = 1'b0;
    #1;
    checkBits({squaredTach, compOut, stage1Busy, stage2Busy}, 4'h0);
    end_of_test();
  end

  // Run needs about 71k cycles; a hang stops at 100k
  initial begin
    #1_000_000;
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    end_of_test();
  end
endmodule : capstan_time_base_comparator_tb
